// ### verilog/vstg_pkg.sv
// Package with register map, field layout and types for the video sync timing generator.
`default_nettype none
package vstg_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int VSTG_NUM_REGS = 19;
  localparam int VSTG_REG_W = 12;
  localparam logic [5:0] REG_STATUS = 6'h00;
  localparam logic [5:0] REG_LINE_FRONT_PORCH = 6'h01;
  localparam logic [5:0] REG_LINE_SYNC_END = 6'h02;
  localparam logic [5:0] REG_LINE_BLANK_END = 6'h03;
  localparam logic [5:0] REG_LINE_CLOCK_TOTAL = 6'h04;
  localparam logic [5:0] REG_FRAME_FRONT_PORCH = 6'h05;
  localparam logic [5:0] REG_FRAME_SYNC_END = 6'h06;
  localparam logic [5:0] REG_FRAME_BLANK_END = 6'h07;
  localparam logic [5:0] REG_FRAME_LINE_TOTAL = 6'h08;
  localparam logic [5:0] REG_EQUALIZATION_PULSE_END = 6'h09;
  localparam logic [5:0] REG_SERRATION_PULSE_END = 6'h0A;
  localparam logic [5:0] REG_EQ_SERR_INTERVAL_START = 6'h0B;
  localparam logic [5:0] REG_EQ_SERR_INTERVAL_END = 6'h0C;
  localparam logic [5:0] REG_VERT_INTERRUPT_ON_LINE = 6'h0D;
  localparam logic [5:0] REG_VERT_INTERRUPT_OFF_LINE = 6'h0E;
  localparam logic [5:0] REG_CURSOR_HORIZ_START = 6'h0F;
  localparam logic [5:0] REG_CURSOR_HORIZ_END = 6'h10;
  localparam logic [5:0] REG_CURSOR_VERT_START = 6'h11;
  localparam logic [5:0] REG_CURSOR_VERT_END = 6'h12;
  localparam logic [5:0] REG_LAST_DATA = 6'h12;
  localparam logic [11:0] REG_RESET_VALUE = 12'h000;
  // ---------------------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------------------
  localparam int ST_SEL0 = 0;
  localparam int ST_SEL1 = 1;
  localparam int ST_SEL2 = 2;
  localparam int ST_MODE_LO = 3;
  localparam int ST_MODE_HI = 4;
  localparam int ST_POL_VCB = 5;
  localparam int ST_POL_VCS = 6;
  localparam int ST_POL_HBL = 7;
  localparam int ST_POL_HSY = 8;
  localparam int ST_EQ_DISABLE = 9;
  localparam int ST_CLK_ENABLE = 10;
  localparam logic [1:0] MODE_INTERLACED = 2'h0;
  localparam logic [1:0] MODE_NI_DOUBLE = 2'h1;
  localparam logic [1:0] MODE_NI_SINGLE = 2'h3;
  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [5:0] addr;
    logic [11:0] data;
  } vstg_wr_t;
  typedef struct packed {
    logic frame_sync_out;
    logic frame_blank_out;
    logic line_out;
    logic line_sync_out;
    logic odd_field;
  } vstg_pins_t;
endpackage
`default_nettype wire

// ### verilog/vstg_load_port.sv
// Register load port: strobe synchroniser, address counter logic and byte assembly.
`default_nettype none
module vstg_load_port
  import vstg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic i_addr_or_value_select,
  input wire logic i_byte_half_select,
  input wire logic [7:0] i_data,
  output logic o_wr_valid,
  output vstg_wr_t o_wr
);
  // ---------------------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------------------
  // The strobe is asynchronous to the pixel clock, so all pins pass three stages.
  logic [2:0] load_sync_ff;
  logic [2:0] sel_sync_ff;
  logic [2:0] half_sync_ff;
  logic [7:0] data_s1_ff, data_s2_ff, data_s3_ff;
  logic load_ff;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      // The strobe idles high, so the stages start high to avoid a false rise after reset.
      load_sync_ff <= 3'h7;
      sel_sync_ff <= 3'h0;
      half_sync_ff <= 3'h0;
      data_s1_ff <= 8'h00;
      data_s2_ff <= 8'h00;
      data_s3_ff <= 8'h00;
    end else begin
      load_sync_ff <= {load_sync_ff[1:0], i_load};
      sel_sync_ff <= {sel_sync_ff[1:0], i_addr_or_value_select};
      half_sync_ff <= {half_sync_ff[1:0], i_byte_half_select};
      data_s1_ff <= i_data;
      data_s2_ff <= data_s1_ff;
      data_s3_ff <= data_s2_ff;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      load_ff <= 1'b1;
    end else if (load_sync_ff[1] == load_sync_ff[2]) begin
      load_ff <= load_sync_ff[2];
    end
  end
  logic load_fall, load_rise;
  assign load_fall = load_ff & ~load_sync_ff[2] & ~load_sync_ff[1];
  assign load_rise = ~load_ff & load_sync_ff[2] & load_sync_ff[1];
  // ---------------------------------------------------------------------------
  // Address counter logic
  // ---------------------------------------------------------------------------
  logic sel_ff, half_ff, auto_ff;
  logic [5:0] addr_ff, start_ff;
  logic [7:0] low_ff;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sel_ff <= 1'b0;
      half_ff <= 1'b0;
      auto_ff <= 1'b0;
    end else if (load_fall) begin
      sel_ff <= sel_sync_ff[2];
      half_ff <= half_sync_ff[2];
      if (!sel_sync_ff[2] && half_sync_ff[2]) begin
        auto_ff <= 1'b1;
      end else if (!sel_sync_ff[2] && !half_sync_ff[2]) begin
        auto_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      addr_ff <= 6'h00;
      start_ff <= 6'h00;
      low_ff <= 8'h00;
    end else if (load_rise) begin
      if (!sel_ff) begin
        addr_ff <= data_s3_ff[5:0];
        start_ff <= data_s3_ff[5:0];
      end else if (!half_ff) begin
        low_ff <= data_s3_ff;
      end else if (auto_ff) begin
        if (addr_ff >= REG_LAST_DATA) begin
          addr_ff <= start_ff;
        end else begin
          addr_ff <= addr_ff + 6'h01;
        end
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Write out
  // ---------------------------------------------------------------------------
  // The low byte is held until the high byte arrives so a register updates whole.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_wr_valid <= 1'b0;
      o_wr <= '0;
    end else begin
      o_wr_valid <= load_rise & sel_ff & half_ff;
      o_wr.addr <= addr_ff;
      o_wr.data <= {data_s3_ff[3:0], low_ff};
    end
  end
endmodule
`default_nettype wire

// ### verilog/vstg_reg_file.sv
// Register file of nineteen 12-bit timing registers with flat read-out.
`default_nettype none
module vstg_reg_file
  import vstg_pkg::*;
#(
  parameter int NUM_REGS = VSTG_NUM_REGS
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_wr_valid,
  input wire vstg_wr_t i_wr,
  output logic [NUM_REGS*VSTG_REG_W-1:0] o_regs
);
  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      logic [VSTG_REG_W-1:0] reg_ff;
      always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
          reg_ff <= REG_RESET_VALUE;
        end else if (i_wr_valid && i_wr.addr == 6'(g)) begin
          reg_ff <= i_wr.data;
        end
      end
      assign o_regs[g*VSTG_REG_W +: VSTG_REG_W] = reg_ff;
    end
  endgenerate
endmodule
`default_nettype wire

// ### verilog/vstg_timing_gen.sv
// Top level of the video sync timing generator: counters, comparators and pin muxing.
`default_nettype none
module vstg_timing_gen
  import vstg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic i_addr_or_value_select,
  input wire logic i_byte_half_select,
  input wire logic [7:0] i_data,
  output logic o_frame_sync,
  output logic o_frame_blank,
  output logic o_line_blank,
  output logic o_line_sync,
  output logic o_odd_field
);
  // ---------------------------------------------------------------------------
  // Load port and register file
  // ---------------------------------------------------------------------------
  logic wr_valid;
  vstg_wr_t wr;
  logic [VSTG_NUM_REGS*VSTG_REG_W-1:0] regs;
  vstg_load_port u_load (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_load(i_load),
    .i_addr_or_value_select(i_addr_or_value_select),
    .i_byte_half_select(i_byte_half_select),
    .i_data(i_data),
    .o_wr_valid(wr_valid),
    .o_wr(wr)
  );
  vstg_reg_file #(
    .NUM_REGS(VSTG_NUM_REGS)
  ) u_regs (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_wr_valid(wr_valid),
    .i_wr(wr),
    .o_regs(regs)
  );
  function automatic logic [11:0] rg(input logic [5:0] a);
    rg = regs[a*VSTG_REG_W +: VSTG_REG_W];
  endfunction
  logic [11:0] status, r_fp, r_hs, r_hb, r_tot;
  logic [11:0] r_vfp, r_vs, r_vb, r_vtot, r_eq, r_se;
  logic [11:0] r_ws, r_we, r_vi_on, r_vi_off, r_ch0, r_ch1, r_cv0, r_cv1;
  assign status = rg(REG_STATUS);
  assign r_fp = rg(REG_LINE_FRONT_PORCH);
  assign r_hs = rg(REG_LINE_SYNC_END);
  assign r_hb = rg(REG_LINE_BLANK_END);
  assign r_tot = rg(REG_LINE_CLOCK_TOTAL);
  assign r_vfp = rg(REG_FRAME_FRONT_PORCH);
  assign r_vs = rg(REG_FRAME_SYNC_END);
  assign r_vb = rg(REG_FRAME_BLANK_END);
  assign r_vtot = rg(REG_FRAME_LINE_TOTAL);
  assign r_eq = rg(REG_EQUALIZATION_PULSE_END);
  assign r_se = rg(REG_SERRATION_PULSE_END);
  assign r_ws = rg(REG_EQ_SERR_INTERVAL_START);
  assign r_we = rg(REG_EQ_SERR_INTERVAL_END);
  assign r_vi_on = rg(REG_VERT_INTERRUPT_ON_LINE);
  assign r_vi_off = rg(REG_VERT_INTERRUPT_OFF_LINE);
  assign r_ch0 = rg(REG_CURSOR_HORIZ_START);
  assign r_ch1 = rg(REG_CURSOR_HORIZ_END);
  assign r_cv0 = rg(REG_CURSOR_VERT_START);
  assign r_cv1 = rg(REG_CURSOR_VERT_END);
  logic [1:0] mode;
  logic interlaced, double_rate, clk_en;
  assign mode = status[ST_MODE_HI:ST_MODE_LO];
  assign interlaced = (mode == MODE_INTERLACED);
  assign double_rate = (mode != MODE_NI_SINGLE);
  assign clk_en = status[ST_CLK_ENABLE];
  // ---------------------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------------------
  // The system clock stands in for the inverted pixel clock, so every output
  // flop here updates on the edge that the pixel falling edge maps onto.
  logic [11:0] hcnt_ff, vcnt_ff, half_tot;
  logic half_ff;
  logic line_end, half_mark;
  assign half_tot = {1'b0, r_tot[11:1]};
  assign line_end = (hcnt_ff >= r_tot);
  assign half_mark = (hcnt_ff == half_tot);
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      hcnt_ff <= 12'h001;
    end else if (clk_en) begin
      hcnt_ff <= line_end ? 12'h001 : hcnt_ff + 12'h001;
    end
  end
  // Vertical unit counter counts half-lines when interlaced; compare in those units.
  logic [12:0] vunit_ff, vunit_max;
  assign vunit_max = interlaced ? {r_vtot, 1'b0} : {1'b0, r_vtot};
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      vunit_ff <= 13'h0001;
      vcnt_ff <= 12'h001;
      half_ff <= 1'b0;
    end else if (clk_en && (line_end || (interlaced && half_mark))) begin
      if (vunit_ff >= vunit_max) begin
        vunit_ff <= 13'h0001;
      end else begin
        vunit_ff <= vunit_ff + 13'h0001;
      end
      if (line_end) begin
        vcnt_ff <= (vcnt_ff >= r_vtot) ? 12'h001 : vcnt_ff + 12'h001;
        if (interlaced && vcnt_ff == {1'b0, r_vtot[11:1]}) begin
          half_ff <= ~half_ff;
        end
        if (vcnt_ff >= r_vtot) begin
          half_ff <= 1'b0;
        end
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Horizontal flags
  // ---------------------------------------------------------------------------
  logic line_blank_ff, hsync_ff, eq_ff, serr_ff, line_gating_ff;
  logic [11:0] hsub;
  assign hsub = (double_rate && hcnt_ff > half_tot) ? hcnt_ff - half_tot : hcnt_ff;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      line_blank_ff <= 1'b0;
      hsync_ff <= 1'b0;
      eq_ff <= 1'b0;
      serr_ff <= 1'b0;
      line_gating_ff <= 1'b0;
    end else if (clk_en) begin
      if (line_end) begin
        line_blank_ff <= 1'b1;
      end else if (hcnt_ff + 12'h001 == r_hb) begin
        line_blank_ff <= 1'b0;
      end
      if (hcnt_ff + 12'h001 == r_fp) begin
        hsync_ff <= 1'b1;
      end else if (hcnt_ff + 12'h001 == r_hs) begin
        hsync_ff <= 1'b0;
      end
      if (hsub + 12'h001 == r_fp) begin
        eq_ff <= 1'b1;
      end else if (hsub + 12'h001 == r_eq) begin
        eq_ff <= 1'b0;
      end
      if (hsub + 12'h001 == r_fp) begin
        serr_ff <= 1'b1;
      end else if (hsub + 12'h001 == r_se) begin
        serr_ff <= 1'b0;
      end
      if (hcnt_ff + 12'h001 == r_ch0) begin
        line_gating_ff <= 1'b1;
      end else if (hcnt_ff + 12'h001 == r_ch1) begin
        line_gating_ff <= 1'b0;
      end
    end
  end
  // Serration low time runs from the porch to serration_pulse_end, so invert its window.
  logic serr_pulse;
  assign serr_pulse = ~serr_ff;
  // ---------------------------------------------------------------------------
  // Vertical flags
  // ---------------------------------------------------------------------------
  logic frame_blank_ff, vsync_ff, vwin_ff, frame_gating_ff, frame_interrupt_pulse_ff;
  logic hb_lead, hs_lead;
  logic [12:0] vu;
  assign hb_lead = clk_en & line_end;
  assign hs_lead = clk_en & (hcnt_ff + 12'h001 == r_fp);
  assign vu = vunit_ff;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      frame_blank_ff <= 1'b0;
      vsync_ff <= 1'b0;
      vwin_ff <= 1'b0;
      frame_gating_ff <= 1'b0;
      frame_interrupt_pulse_ff <= 1'b0;
    end else begin
      if (hb_lead) begin
        if (vu >= vunit_max) begin
          frame_blank_ff <= 1'b1;
        end else if (vu + 13'h0001 == {1'b0, r_vb}) begin
          frame_blank_ff <= 1'b0;
        end
        if (vcnt_ff + 12'h001 == r_cv0) begin
          frame_gating_ff <= 1'b1;
        end else if (vcnt_ff + 12'h001 == r_cv1) begin
          frame_gating_ff <= 1'b0;
        end
        if (vu + 13'h0001 == {1'b0, r_vi_on}) begin
          frame_interrupt_pulse_ff <= 1'b1;
        end else if (vu + 13'h0001 == {1'b0, r_vi_off}) begin
          frame_interrupt_pulse_ff <= 1'b0;
        end
        if (vu >= vunit_max || vu + 13'h0001 == {1'b0, r_ws}) begin
          vwin_ff <= (r_ws <= 12'h001) || (vu + 13'h0001 == {1'b0, r_ws});
        end else if (vu + 13'h0001 == {1'b0, r_we}) begin
          vwin_ff <= 1'b0;
        end
      end
      if (hs_lead) begin
        if (vu + 13'h0001 == {1'b0, r_vfp}) begin
          vsync_ff <= 1'b1;
        end else if (vu + 13'h0001 == {1'b0, r_vs}) begin
          vsync_ff <= 1'b0;
        end
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Composite forming and pin selection
  // ---------------------------------------------------------------------------
  logic comp_sync, comp_blank, cursor, eq_on;
  assign eq_on = ~status[ST_EQ_DISABLE];
  always_comb begin
    comp_blank = line_blank_ff | frame_blank_ff;
    if (eq_on && vsync_ff) begin
      comp_sync = serr_pulse;
    end else if (eq_on && vwin_ff) begin
      comp_sync = eq_ff;
    end else begin
      comp_sync = hsync_ff | vsync_ff;
    end
  end
  assign cursor = line_gating_ff & frame_gating_ff;
  vstg_pins_t nxt_pins;
  always_comb begin
    nxt_pins.frame_blank_out = status[ST_SEL0] ? frame_blank_ff : comp_blank;
    nxt_pins.frame_sync_out = status[ST_SEL1] ? vsync_ff : comp_sync;
    if (status[ST_SEL0]) begin
      nxt_pins.line_out = line_blank_ff;
    end else if (status[ST_SEL2]) begin
      nxt_pins.line_out = cursor;
    end else begin
      nxt_pins.line_out = line_gating_ff;
    end
    if (status[ST_SEL1]) begin
      nxt_pins.line_sync_out = hsync_ff;
    end else if (status[ST_SEL2]) begin
      nxt_pins.line_sync_out = frame_interrupt_pulse_ff;
    end else begin
      nxt_pins.line_sync_out = frame_gating_ff;
    end
    nxt_pins.odd_field = interlaced ? ~half_ff : 1'b1;
  end
  // Output flops hold state while the clock-enable bit is off, freezing the pins.
  vstg_pins_t pins_ff;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pins_ff <= '0;
    end else if (clk_en) begin
      pins_ff <= nxt_pins;
    end
  end
  assign o_frame_blank = pins_ff.frame_blank_out ^~ ~status[ST_POL_VCB] ? 1'b0 : 1'b1;
  assign o_frame_sync = status[ST_POL_VCS] ? pins_ff.frame_sync_out : ~pins_ff.frame_sync_out;
  assign o_line_blank = status[ST_POL_HBL] ? pins_ff.line_out : ~pins_ff.line_out;
  assign o_line_sync = status[ST_POL_HSY] ? pins_ff.line_sync_out : ~pins_ff.line_sync_out;
  assign o_odd_field = pins_ff.odd_field;
endmodule
`default_nettype wire

// ### verif/vstg_host_model.sv
// Host model that programs the timing generator through its load strobe port.
`default_nettype none
module vstg_host_model (
  input wire logic i_sys_clk,
  output var logic o_load,
  output var logic o_addr_or_value_select,
  output var logic o_byte_half_select,
  output var logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_load = 1'b1;
    o_addr_or_value_select = 1'b0;
    o_byte_half_select = 1'b0;
    o_data = 8'h00;
  end
  // ------------------------
  // Load cycles
  // ------------------------
  // Each level is held 6 clocks, twice the synchroniser depth, so no edge is lost.
  task automatic load_cycle(input logic sel, input logic half, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_load <= 1'b0;
    o_addr_or_value_select <= sel;
    o_byte_half_select <= half;
    o_data <= d;
    repeat (6) @(posedge i_sys_clk);
    o_load <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    o_data <= ~d;
  endtask
  task automatic write_pair(input logic [11:0] v, input logic [3:0] nib);
    load_cycle(1'b1, 1'b0, v[7:0]);
    load_cycle(1'b1, 1'b1, {nib, v[11:8]});
  endtask
  task automatic manual_write(input logic [5:0] a, input logic [11:0] v, input logic [3:0] nib);
    load_cycle(1'b0, 1'b0, {2'h0, a});
    write_pair(v, nib);
  endtask
endmodule
`default_nettype wire

// ### verif/vstg_timing_props.sv
// Checker of line and frame timing relations at the generator pins.
`default_nettype none
module vstg_timing_props (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic o_frame_sync,
  input wire logic o_frame_blank,
  input wire logic o_line_blank,
  input wire logic o_line_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // The polarity flip of a status write makes edges that are not timing, so wait for a line.
  logic run_ff;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) run_ff <= 1'b0;
    else if ($rose(o_line_blank)) run_ff <= 1'b1;
  end
  // ------------------------
  // Timing relations
  // ------------------------
  sequence s_porch;
    (o_line_blank && !o_line_sync)[*2] ##1 $rose(o_line_sync);
  endsequence
  sequence s_blank;
    o_line_blank[*8] ##1 !o_line_blank;
  endsequence
  sequence s_sync;
    o_line_sync[*3] ##1 !o_line_sync;
  endsequence
  a_fblank_rise_align: assert property ($rose(o_frame_blank) |-> $rose(o_line_blank))
    else $error("frame blank rose off a line blank edge");
  a_fblank_fall_align: assert property (run_ff && $fell(o_frame_blank) |-> $rose(o_line_blank))
    else $error("frame blank fell off a line blank edge");
  a_fsync_rise_align: assert property ($rose(o_frame_sync) |-> $rose(o_line_sync))
    else $error("frame sync rose off a line sync edge");
  a_fsync_fall_align: assert property (run_ff && $fell(o_frame_sync) |-> $rose(o_line_sync))
    else $error("frame sync fell off a line sync edge");
  a_line_period: assert property ($rose(o_line_blank) |-> ##20 $rose(o_line_blank))
    else $error("line period wrong");
  a_blank_width: assert property ($rose(o_line_blank) |-> s_blank)
    else $error("line blank width wrong");
  a_porch_width: assert property ($rose(o_line_blank) |-> s_porch)
    else $error("line front porch wrong");
  a_sync_width: assert property ($rose(o_line_sync) |-> s_sync)
    else $error("line sync width wrong");
  a_fsync_width: assert property ($rose(o_frame_sync) |-> ##40 $fell(o_frame_sync))
    else $error("frame sync width wrong");
endmodule
bind vstg_timing_gen vstg_timing_props u_props (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .o_frame_sync(o_frame_sync), .o_frame_blank(o_frame_blank), .o_line_blank(o_line_blank),
  .o_line_sync(o_line_sync));
`default_nettype wire

// ### verif/testbench.sv
// Self-checking testbench of the timing generator with manual and auto register loading.
`default_nettype none
module testbench
  import vstg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, load, sel, half, fs, fb, lb, ls, odd, watch;
  logic [7:0] data;
  logic [11:0] fb7;
  logic [3:0] sig, prev, live;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int run[4];
  int exp_q[4][$];
  integer seed = 57520;
  // Even line total, edges programmed as offset plus one, whole-line frame total.
  logic [11:0] prog[1:8] = '{12'h003, 12'h006, 12'h009, 12'h014, 12'h002, 12'h004,
    12'h005, 12'h00A};
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  vstg_host_model host (.i_sys_clk(clk), .o_load(load), .o_addr_or_value_select(sel),
    .o_byte_half_select(half), .o_data(data));
  vstg_timing_gen uut (.i_sys_clk(clk), .i_reset(rst), .i_load(load),
    .i_addr_or_value_select(sel), .i_byte_half_select(half), .i_data(data),
    .o_frame_sync(fs), .o_frame_blank(fb), .o_line_blank(lb), .o_line_sync(ls),
    .o_odd_field(odd));
  // ------------------------
  // Checking
  // ------------------------
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("unexpected at %0t: run hung", $time);
      complete_run();
    end
  end
  // Widths count only from a rise seen while watching, so stale levels never score.
  always @(posedge clk) begin
    sig = {fs, fb, ls, lb};
    for (int i = 0; i < 4; i++) begin
      if (watch !== 1'b1) live[i] = 1'b0;
      else if (sig[i] === 1'b1 && prev[i] !== 1'b1) begin
        run[i] = 1;
        live[i] = 1'b1;
      end else if (sig[i] === 1'b1) run[i]++;
      else if (live[i] === 1'b1 && prev[i] === 1'b1 && exp_q[i].size() > 0) begin
        comparisons++;
        if (run[i] != exp_q[i].pop_front()) begin
          errors++;
          $display("unexpected at %0t: pin %0d width %0d", $time, i, run[i]);
        end
      end
    end
    prev = sig;
  end
  task automatic check_frames(input int fb_w, input string name);
    for (int k = 0; k < 12; k++) begin
      exp_q[0].push_back(8);
      exp_q[1].push_back(3);
    end
    for (int k = 0; k < 2; k++) begin
      exp_q[2].push_back(fb_w);
      exp_q[3].push_back(40);
    end
    watch <= 1'b1;
    repeat (700) @(posedge clk);
    watch <= 1'b0;
    comparisons++;
    if (odd !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: odd field low", $time);
    end
    for (int i = 0; i < 4; i++) begin
      comparisons++;
      if (exp_q[i].size() != 0) begin
        errors++;
        $display("unexpected at %0t: pin %0d pulses missing", $time, i);
        exp_q[i].delete();
      end
    end
    $display("test %s done", name);
  endtask
  // ------------------------
  // Scenarios
  // ------------------------
  initial begin
    rst = 1'b1;
    watch = 1'b0;
    prev = 4'h0;
    live = 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int a = 1; a <= 8; a++) host.manual_write(6'(a), prog[a], 4'($random(seed)));
    host.manual_write(6'h13, 12'hFFF, 4'h0);
    host.manual_write(REG_STATUS, 12'h5FF, 4'($random(seed)));
    check_frames(80, "manual");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    fb7 = 12'h005 + 12'($random(seed) & 3);
    host.load_cycle(1'b0, 1'b1, 8'h01);
    // A wrong first porch value shows unless the counter wraps back onto it.
    host.write_pair(12'h005, 4'($random(seed)));
    for (int a = 2; a <= 18; a++)
      host.write_pair(a == 7 ? fb7 : (a <= 8 ? prog[a] : 12'($random(seed))), 4'h0);
    host.write_pair(12'h003, 4'($random(seed)));
    host.load_cycle(1'b0, 1'b0, {2'h0, REG_STATUS});
    host.write_pair(12'h5FF, 4'h0);
    check_frames((int'(fb7) - 1) * 20, "auto");
    complete_run();
  end
endmodule
`default_nettype wire
